/* File: logic/irl_pkg.sv */
// shared constants, types and decode helpers of the interrupt request level controller
`default_nettype none

package irl_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_FLAGS_C = 16'hf02c;
    localparam logic [15:0] IDX_FLAGS_D = 16'hf02e;
    localparam logic [15:0] IDX_LVL_EN = 16'hf030;
    localparam logic [15:0] IDX_CUR_LVL = 16'hf032;
    localparam logic [15:0] IDX_MASK_LVL = 16'hf033;
    localparam logic [15:0] IDX_STATUS = 16'hf040;

    localparam int ADDR_W = 18;
    localparam logic [17:0] ADDR_FLAGS_C = {IDX_FLAGS_C, 2'b00};
    localparam logic [17:0] ADDR_FLAGS_D = {IDX_FLAGS_D, 2'b00};
    localparam logic [17:0] ADDR_LVL_EN = {IDX_LVL_EN, 2'b00};
    localparam logic [17:0] ADDR_CUR_LVL = {IDX_CUR_LVL, 2'b00};
    localparam logic [17:0] ADDR_MASK_LVL = {IDX_MASK_LVL, 2'b00};
    localparam logic [17:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // ------------------------------------------------------------------
    // implemented bits and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] BANK_C_IMPL = 16'h43c7;
    localparam logic [15:0] BANK_D_IMPL = 16'h3e7f;
    localparam logic [31:0] FLAGS_IMPL = {BANK_D_IMPL, BANK_C_IMPL};
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic LVL_EN_RST = 1'b0;
    localparam logic [7:0] CUR_LVL_RST = 8'h00;
    localparam logic [3:0] MASK_LVL_RST = 4'h0;
    localparam int LVL_EN_BIT = 0;
    localparam int CUR_NMI_BIT = 7;
    localparam int NUM_SRC = 32;

    // ------------------------------------------------------------------
    // priority ranks: 0 none, 1..4 maskable levels, 5 non-maskable
    // ------------------------------------------------------------------
    typedef logic [1:0] irl_level_t;
    typedef logic [2:0] irl_rank_t;
    localparam irl_rank_t RANK_NONE = 3'h0;
    localparam irl_rank_t RANK_NMI = 3'h5;

    typedef struct packed {
        logic valid;
        logic [4:0] id;
        irl_level_t level;
    } irl_cpu_req_s;

    typedef struct packed {
        logic take;
        logic [4:0] id;
        logic nmi_take;
    } irl_cpu_ack_s;

    // highest level marked in a level1..level4 bit vector
    function automatic irl_rank_t irl_top_rank(input logic [3:0] v);
        irl_rank_t r;
        r = RANK_NONE;
        for (int k = 0; k < 4; k++) begin
            if (v[k]) begin
                r = 3'(k + 1);
            end
        end
        return r;
    endfunction : irl_top_rank

endpackage : irl_pkg

`default_nettype wire

/* File: logic/irl_ctrl.sv */
// interrupt request flag banks with priority level control behind an apb slave
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1: events set flags regardless of enables
// R2: present only enabled flags, master enable gates
// R3: software writing one raises the interrupt
// R4: flag clears when cpu accepts it
// R5: bank c implements bits 14,9..6,2..0 only
// R6: bank d implements bits 13..9, 6..0
// R7: byte and halfword access, reset zero
// R8: software modifies single flags bitwise
// R9: level control on/off bit, reset zero
// R10: software disables level control in safe order
// R11: software enables level control while quiet
// R12: acceptance sets matching current level bit
// R13: block requests below level in service
// R14: nested levels stay set until released
// R15: any write clears highest set level
// R16: handler end writes current level once
// R17: bit7 nmi, bits3..0 levels 4..1
// R18: mask level writable only while enabled
// R19: hold requests at or below mask
// R20: lowering mask releases held request
// R21: mask bits 3..1 are levels 4..2
// R22: mask bit 0 is level 1
// R23: level field 00 lowest, 11 highest
// R24: source enable one forwards, zero blocks
// R25: acceptance clears master enable only
module irl_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [irl_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral events, bank c in low half
    input wire logic [irl_pkg::NUM_SRC-1:0] source_event,
    // per-source enables and level fields from their registers
    input wire logic [irl_pkg::NUM_SRC-1:0] source_enable,
    input wire logic [2*irl_pkg::NUM_SRC-1:0] level_assign_reg,
    // cpu side
    input wire logic master_interrupt_enable,
    input wire irl_pkg::irl_cpu_ack_s cpu_ack,
    output irl_pkg::irl_cpu_req_s cpu_req,
    output logic master_enable_clear,
    output logic level_control_on
);
    import irl_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0] request_flags;
    logic [7:0] current_service_level;
    logic [3:0] mask_level;

    logic [31:0] next_request_flags;
    logic [7:0] next_current_service_level;
    logic [3:0] next_mask_level;
    logic next_level_control_on;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic bus_write;
    logic bus_setup;
    logic hit_c, hit_d, hit_en, hit_cur, hit_mask, hit_stat;
    logic [15:0] lane16;
    logic [31:0] flag_lane;
    logic [31:0] rd_word;
    logic rd_err;

    assign bus_setup = psel & ~penable;
    assign bus_write = psel & penable & pready & pwrite;
    assign hit_c = (paddr == ADDR_FLAGS_C);
    assign hit_d = (paddr == ADDR_FLAGS_D);
    assign hit_en = (paddr == ADDR_LVL_EN);
    assign hit_cur = (paddr == ADDR_CUR_LVL);
    assign hit_mask = (paddr == ADDR_MASK_LVL);
    assign hit_stat = (paddr == ADDR_STATUS);
    assign lane16 = {{8{pstrb[1]}}, {8{pstrb[0]}}}; // R7

    always_comb begin
        flag_lane = 32'h0000_0000;
        if (hit_c) begin
            flag_lane = {16'h0000, lane16};
        end else if (hit_d) begin
            flag_lane = {lane16, 16'h0000};
        end
    end

    // ------------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------------
    // order matters: software write, then acceptance clear, then events,
    // so an event in the same cycle as any clear is never lost
    always_comb begin
        next_request_flags = request_flags;
        if (bus_write) begin
            next_request_flags = (request_flags & ~flag_lane)
                | ({pwdata[15:0], pwdata[15:0]} & flag_lane); // R3 R8
        end
        if (cpu_ack.take) begin
            next_request_flags[cpu_ack.id] = 1'b0; // R4
        end
        next_request_flags = (next_request_flags | source_event) & FLAGS_IMPL; // R1 R5 R6
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            request_flags <= FLAGS_RST; // R7
        end else begin
            request_flags <= next_request_flags;
        end
    end

    // ------------------------------------------------------------------
    // level control enable
    // ------------------------------------------------------------------
    always_comb begin
        next_level_control_on = level_control_on;
        if (bus_write && hit_en && pstrb[0]) begin
            next_level_control_on = pwdata[LVL_EN_BIT]; // R9
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            level_control_on <= LVL_EN_RST; // R9
        end else begin
            level_control_on <= next_level_control_on;
        end
    end

    // ------------------------------------------------------------------
    // current service level
    // ------------------------------------------------------------------
    irl_level_t ack_level;
    assign ack_level = level_assign_reg[2*cpu_ack.id +: 2];

    always_comb begin
        next_current_service_level = current_service_level;
        // release first so a same-cycle acceptance still lands
        if (bus_write && hit_cur && pstrb[0]) begin
            if (current_service_level[CUR_NMI_BIT]) begin
                next_current_service_level[CUR_NMI_BIT] = 1'b0; // R15 R16
            end else begin
                for (int k = 0; k < 4; k++) begin
                    if (irl_top_rank(current_service_level[3:0]) == 3'(k + 1)) begin
                        next_current_service_level[k] = 1'b0; // R15
                    end
                end
            end
        end
        if (level_control_on && cpu_ack.take) begin
            next_current_service_level[ack_level] = 1'b1; // R12 R14 R23
        end
        if (level_control_on && cpu_ack.nmi_take) begin
            next_current_service_level[CUR_NMI_BIT] = 1'b1; // R12 R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            current_service_level <= CUR_LVL_RST;
        end else begin
            current_service_level <= next_current_service_level;
        end
    end

    // ------------------------------------------------------------------
    // mask level
    // ------------------------------------------------------------------
    always_comb begin
        next_mask_level = mask_level;
        if (bus_write && hit_mask && pstrb[0] && level_control_on) begin
            next_mask_level = pwdata[3:0]; // R18 R21 R22
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mask_level <= MASK_LVL_RST; // R18
        end else begin
            mask_level <= next_mask_level;
        end
    end

    // ------------------------------------------------------------------
    // eligibility per source
    // ------------------------------------------------------------------
    // decided on next-state values so the registered request never
    // repeats a flag that is being cleared in this very cycle
    irl_rank_t serving_rank;
    irl_rank_t masked_rank;
    logic [NUM_SRC-1:0] eligible;

    assign serving_rank = next_current_service_level[CUR_NMI_BIT] ? RANK_NMI
        : irl_top_rank(next_current_service_level[3:0]); // R17
    assign masked_rank = irl_top_rank(next_mask_level); // R21 R22

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        irl_rank_t rank;
        logic blocked;
        assign rank = 3'({1'b0, level_assign_reg[2*i +: 2]}) + 3'h1; // R23
        assign blocked = next_level_control_on
            & ((rank < serving_rank) | (rank <= masked_rank)); // R13 R19 R20
        assign eligible[i] = next_request_flags[i] & source_enable[i] & ~blocked; // R2 R24
    end

    // ------------------------------------------------------------------
    // arbitration: highest level while level control is on, then lowest index
    // ------------------------------------------------------------------
    logic best_found;
    logic [4:0] best_id;
    irl_level_t best_level;

    always_comb begin
        best_found = 1'b0;
        best_id = 5'h00;
        best_level = 2'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible[i]) begin
                if (!best_found || (next_level_control_on
                        && level_assign_reg[2*i +: 2] > best_level)) begin
                    best_found = 1'b1;
                    best_id = 5'(i);
                    best_level = level_assign_reg[2*i +: 2];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // cpu request
    // ------------------------------------------------------------------
    // a flag set by software shows here on the next edge, leaving the
    // core one instruction before it branches
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cpu_req <= '0;
        end else begin
            cpu_req.valid <= best_found & master_interrupt_enable; // R2 R3
            cpu_req.id <= best_id;
            cpu_req.level <= best_level;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            master_enable_clear <= 1'b0;
        end else begin
            master_enable_clear <= cpu_ack.take; // R25
        end
    end

    // ------------------------------------------------------------------
    // apb read and answer
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (hit_c) begin
            rd_word = {16'h0000, request_flags[15:0]};
        end else if (hit_d) begin
            rd_word = {16'h0000, request_flags[31:16]};
        end else if (hit_en) begin
            rd_word = {31'h0000_0000, level_control_on};
        end else if (hit_cur) begin
            rd_word = {24'h00_0000, current_service_level}; // R17
        end else if (hit_mask) begin
            rd_word = {28'h000_0000, mask_level};
        end else if (hit_stat) begin
            rd_word = {18'h0_0000, serving_rank, masked_rank, cpu_req.level,
                cpu_req.id, cpu_req.valid};
        end else begin
            rd_err = 1'b1;
        end
    end

    // one wait-free access phase: pready rises in the cycle after setup
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= bus_setup;
            pslverr <= bus_setup & rd_err;
        end
    end

    // read data is captured at setup, so a flag set during access shows next read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (bus_setup && !pwrite) begin
            prdata <= rd_word;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule : irl_ctrl

`default_nettype wire

/* File: dv/irl_ctrl_monitor.sv */
// port-level checks of the interrupt request level controller
`timescale 1ns/1ns
`default_nettype none
module irl_ctrl_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [irl_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sources and cpu side
    input wire logic [irl_pkg::NUM_SRC-1:0] source_event,
    input wire logic [irl_pkg::NUM_SRC-1:0] source_enable,
    input wire logic [2*irl_pkg::NUM_SRC-1:0] level_assign_reg,
    input wire logic master_interrupt_enable,
    input wire irl_pkg::irl_cpu_ack_s cpu_ack,
    input wire irl_pkg::irl_cpu_req_s cpu_req,
    input wire logic master_enable_clear,
    input wire logic level_control_on
);
    import irl_pkg::*;
    logic [31:0] en_q;
    logic [2*NUM_SRC-1:0] lvl_q;
    logic en_val;
    wire logic en_wr = psel && penable && pready && pwrite && paddr == ADDR_LVL_EN && pstrb[0];
    // requests are registered, so they answer to last cycle's enables
    always_ff @(posedge ref_clk) begin
        en_q <= source_enable;
        lvl_q <= level_assign_reg;
        if (en_wr) begin
            en_val <= pwdata[0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    take_clears_mie_a: assert property (cpu_ack.take |=> master_enable_clear)
        else $error("no master enable clear");
    clear_needs_take_a: assert property (master_enable_clear |-> $past(cpu_ack.take))
        else $error("stray master enable clear");
    req_needs_mie_a: assert property (cpu_req.valid |-> $past(master_interrupt_enable))
        else $error("request without master enable");
    req_needs_enable_a: assert property (cpu_req.valid |-> en_q[cpu_req.id])
        else $error("request from disabled source");
    event_to_cpu_a: assert property ((source_event & source_enable) != '0
        && master_interrupt_enable && !level_control_on && !cpu_ack.take |=> cpu_req.valid)
        else $error("event not presented");
    lvl_on_follows_a: assert property (en_wr |=> level_control_on == en_val)
        else $error("level control bit not followed");
    req_level_match_a: assert property (cpu_req.valid |-> cpu_req.level == lvl_q[2*cpu_req.id +: 2])
        else $error("request level does not match source");
    cover property (cpu_ack.take);
    cover property (cpu_ack.nmi_take);
    cover property (pslverr);
    cover property (level_control_on && cpu_ack.take);
endmodule : irl_ctrl_monitor
`default_nettype wire

/* File: dv/irl_cpu_model.sv */
// cpu core model that accepts requests and records what it took
`timescale 1ns/1ns
`default_nettype none
module irl_cpu_model (
    // clock, reset and bench controls
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mie_set,
    input wire logic [1:0] lag,
    input wire logic nmi_set,
    // interrupt path
    input wire irl_pkg::irl_cpu_req_s cpu_req,
    output logic master_interrupt_enable,
    output irl_pkg::irl_cpu_ack_s cpu_ack,
    output logic [4:0] last_id,
    output logic [7:0] take_cnt
);
    import irl_pkg::*;
    logic [1:0] hold;
    // mie drops with the take itself, so nothing is taken twice
    always_ff @(posedge ref_clk) begin
        cpu_ack <= '0;
        // non-maskable acceptance ignores the master enable
        cpu_ack.nmi_take <= nmi_set & rst_n;
        if (!rst_n) begin
            master_interrupt_enable <= 1'b0;
            hold <= 2'h0;
            last_id <= 5'h0;
            take_cnt <= 8'h0;
        end else if (mie_set) begin
            master_interrupt_enable <= 1'b1;
        end else if (cpu_req.valid && master_interrupt_enable && !cpu_ack.take) begin
            hold <= hold + 2'h1;
            if (hold == lag) begin
                hold <= 2'h0;
                cpu_ack.take <= 1'b1;
                cpu_ack.id <= cpu_req.id;
                master_interrupt_enable <= 1'b0;
                last_id <= cpu_req.id;
                take_cnt <= take_cnt + 8'h1;
            end
        end
    end
endmodule : irl_cpu_model
`default_nettype wire

/* File: dv/irl_ctrl_test.sv */
// self-checking bench of the interrupt request level controller
`timescale 1ns/1ns
`default_nettype none
module irl_ctrl_test;
    import irl_pkg::*;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic [31:0] exp;
        logic err;
    } irl_row_s;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mie_set = 1'b0, nmi_set = 1'b0, er;
    logic [31:0] pwdata = '0, source_event = '0, source_enable = '0, prdata, rd;
    logic [3:0] pstrb = '0;
    logic [63:0] level_assign_reg = '0;
    logic [1:0] lag = 2'h0;
    logic pready, pslverr, master_enable_clear, level_control_on, master_interrupt_enable;
    irl_cpu_ack_s cpu_ack;
    irl_cpu_req_s cpu_req;
    logic [4:0] last_id;
    logic [7:0] take_cnt;
    int num_errors = 0;
    int comparisons = 0;
    irl_row_s rows [11] = '{
        '{ADDR_FLAGS_C, 32'hffff, 4'h3, 32'h43c7, 1'b0},
        '{ADDR_FLAGS_C, 32'h0, 4'h3, 32'h0, 1'b0},
        '{ADDR_FLAGS_D, 32'hffff, 4'h3, 32'h3e7f, 1'b0},
        '{ADDR_FLAGS_D, 32'h0, 4'h1, 32'h3e00, 1'b0},
        '{ADDR_FLAGS_D, 32'h0, 4'h2, 32'h0, 1'b0},
        '{ADDR_MASK_LVL, 32'hff, 4'h1, 32'h0, 1'b0},
        '{ADDR_LVL_EN, 32'hff, 4'h1, 32'h1, 1'b0},
        '{ADDR_MASK_LVL, 32'hff, 4'h1, 32'hf, 1'b0},
        '{ADDR_MASK_LVL, 32'h0, 4'h1, 32'h0, 1'b0},
        '{ADDR_LVL_EN, 32'h0, 4'h1, 32'h0, 1'b0},
        '{18'h3c0d0, 32'hff, 4'hf, 32'h0, 1'b1}};
    always #10 ref_clk = ~ref_clk;
    irl_ctrl irl_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .source_event(source_event),
        .source_enable(source_enable), .level_assign_reg(level_assign_reg),
        .master_interrupt_enable(master_interrupt_enable), .cpu_ack(cpu_ack),
        .cpu_req(cpu_req), .master_enable_clear(master_enable_clear),
        .level_control_on(level_control_on));
    irl_cpu_model irl_cpu_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .mie_set(mie_set),
        .lag(lag), .nmi_set(nmi_set), .cpu_req(cpu_req),
        .master_interrupt_enable(master_interrupt_enable),
        .cpu_ack(cpu_ack), .last_id(last_id), .take_cnt(take_cnt));
    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang;
        num_errors++;
        $display("ERROR %0t: wait ran out", $time);
        final_report();
    endtask : hang
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, 4'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic ev(input int i);
        source_event[i] <= 1'b1;
        @(posedge ref_clk);
        source_event[i] <= 1'b0;
        @(posedge ref_clk);
    endtask : ev
    task automatic set_mie;
        mie_set <= 1'b1;
        @(posedge ref_clk);
        mie_set <= 1'b0;
        @(posedge ref_clk);
    endtask : set_mie
    task automatic wait_take(input logic [7:0] n, input logic [4:0] id);
        int k;
        k = 0;
        while (take_cnt !== n && k < 50) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 50) hang();
        chk(32'(last_id), 32'(id));
    endtask : wait_take
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b1, rows[i].wdata, rows[i].strb);
            rdc(rows[i].addr, rows[i].exp);
            chk({31'h0, er}, {31'h0, rows[i].err});
        end
        apb(ADDR_FLAGS_C, 1'b1, 32'hffff, 4'h3);
        apb(ADDR_LVL_EN, 1'b1, 32'h1, 4'h1);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) if (i < 8) rdc(rows[i].addr, 32'h0);
        rdc(ADDR_CUR_LVL, 32'h0);
        ev(1);
        rdc(ADDR_FLAGS_C, 32'h2);
        set_mie();
        repeat (6) @(posedge ref_clk);
        chk(32'(take_cnt), 32'h0);
        source_enable[1] <= 1'b1;
        wait_take(8'h1, 5'd1);
        rdc(ADDR_FLAGS_C, 32'h0);
        chk(32'(cpu_req.valid), 32'h0);
        set_mie();
        ev(1);
        wait_take(8'h2, 5'd1);
        source_enable[16] <= 1'b1;
        lag <= 2'h2;
        set_mie();
        apb(ADDR_FLAGS_D, 1'b1, 32'h1, 4'h1);
        chk(32'(cpu_req.valid), 32'h1);
        wait_take(8'h3, 5'd16);
        lag <= 2'h0;
        apb(ADDR_LVL_EN, 1'b1, 32'h1, 4'h1);
        level_assign_reg <= 64'hb020;
        source_enable <= 32'hc5;
        set_mie();
        ev(2);
        wait_take(8'h4, 5'd2);
        rdc(ADDR_CUR_LVL, 32'h4);
        set_mie();
        ev(0);
        repeat (8) @(posedge ref_clk);
        chk(32'(take_cnt), 32'h4);
        ev(6);
        wait_take(8'h5, 5'd6);
        rdc(ADDR_CUR_LVL, 32'hc);
        apb(ADDR_CUR_LVL, 1'b1, 32'hff, 4'h1);
        rdc(ADDR_CUR_LVL, 32'h4);
        apb(ADDR_CUR_LVL, 1'b1, 32'h0, 4'h1);
        set_mie();
        wait_take(8'h6, 5'd0);
        apb(ADDR_CUR_LVL, 1'b1, 32'h0, 4'h1);
        apb(ADDR_MASK_LVL, 1'b1, 32'h4, 4'h1);
        set_mie();
        ev(7);
        repeat (8) @(posedge ref_clk);
        chk(32'(take_cnt), 32'h6);
        rdc(ADDR_STATUS, 32'h300);
        apb(ADDR_MASK_LVL, 1'b1, 32'h2, 4'h1);
        wait_take(8'h7, 5'd7);
        nmi_set <= 1'b1;
        @(posedge ref_clk);
        nmi_set <= 1'b0;
        @(posedge ref_clk);
        rdc(ADDR_CUR_LVL, 32'h84);
        apb(ADDR_CUR_LVL, 1'b1, 32'h0, 4'h1);
        rdc(ADDR_CUR_LVL, 32'h4);
        apb(ADDR_CUR_LVL, 1'b1, 32'h0, 4'h1);
        level_assign_reg <= '0;
        source_enable <= '0;
        rdc(ADDR_CUR_LVL, 32'h0);
        apb(ADDR_LVL_EN, 1'b1, 32'h0, 4'h1);
        rdc(ADDR_LVL_EN, 32'h0);
        final_report();
    end
endmodule : irl_ctrl_test
bind irl_ctrl irl_ctrl_monitor irl_ctrl_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .source_event(source_event), .source_enable(source_enable),
    .level_assign_reg(level_assign_reg), .master_interrupt_enable(master_interrupt_enable),
    .cpu_ack(cpu_ack), .cpu_req(cpu_req), .master_enable_clear(master_enable_clear),
    .level_control_on(level_control_on));
`default_nettype wire
